// *** design/fmu_pkg.sv ***
// Constants and types shared by the fractional multiply and mul-sub unit.
// Operation
// RQ1: A Q15 lane with both inputs 0x8000 gives 0x7FFF and sets flag bit 21.
// RQ2: An unsaturated Q15 lane shifts its product left one and keeps 31..16.
// RQ3: The Q15 pair packs the upper lane in 31..16 and the lower in 15..0.
// RQ4: The Q31 multiply shifts its 64-bit product left one, keeps upper 32.
// RQ5: A Q31 multiply of two most negative inputs gives the largest Q31.
// RQ6: A saturating Q31 word multiply writes a one to overflow flag bit 21.
// RQ7: Saturating multiplies leave accumulators one to three unchanged.
// RQ8: No exception depends on operand values; overflow goes to flags only.
// RQ9: Absent or disabled extension raises its exception and runs nothing.
// RQ10: Mul-sub decodes by major 000000, minor 111100, sub 10110010.
// RQ11: The 2-bit select picks one of four accumulators, zero the base one.
// RQ12: Mul-sub takes lower from upper halfword product as 33-bit value.
// RQ13: The difference is sign-extended and added unsaturated to the sum.
// RQ14: Mul-sub-accumulate never modifies any overflow flag bit.
// RQ15: Software saves accumulator zero around saturating multiplies.
// RQ16: Overflow flags are set by sticky OR and never cleared here.
package fmu_pkg;
  localparam int          OP_W        = 32;
  localparam int          ACC_W       = 64;
  localparam int          NUM_ACC     = 4;
  localparam int          FLAG_W      = 8;
  localparam int          FLAG_LSB    = 16;
  localparam int          SAT_BIT     = 21;
  localparam logic [5:0]  MAJOR_OP    = 6'h00;
  localparam logic [5:0]  MINOR_OP    = 6'h3C;
  localparam logic [7:0]  MULSA_SUB   = 8'hB2;
  localparam logic [9:0]  Q15_SUB     = 10'h155;
  localparam logic [9:0]  Q31_SUB     = 10'h195;
  localparam logic [15:0] Q15_MIN     = 16'h8000;
  localparam logic [15:0] Q15_MAX     = 16'h7FFF;
  localparam logic [31:0] Q31_MIN     = 32'h80000000;
  localparam logic [31:0] Q31_MAX     = 32'h7FFFFFFF;
  // Operation chosen by the decoder.
  typedef enum logic [1:0]
  {
    FMU_OP_NONE  = 2'b00,
    FMU_OP_Q15   = 2'b01,
    FMU_OP_Q31   = 2'b10,
    FMU_OP_MULSA = 2'b11
  } fmu_op_t;
endpackage

// *** design/fmu_q15_lane.sv ***
// One saturating Q15 lane of the paired halfword multiply.
`timescale 1ns/10ps
module fmu_q15_lane
  import fmu_pkg::*;
(
  input  wire logic [15:0] a_in,
  input  wire logic [15:0] b_in,
  output logic      [15:0] lane_out,
  output logic             lane_sat
);
  wire logic signed [31:0] prod;
  wire logic        [31:0] shifted;

  // Signed product, shifted left with a zero fill.
  assign prod     = $signed(a_in) * $signed(b_in);
  assign shifted  = {prod[30:0], 1'b0};                      // RQ2
  assign lane_sat = (a_in == Q15_MIN) && (b_in == Q15_MIN);  // RQ1
  assign lane_out = lane_sat ? Q15_MAX : shifted[31:16];     // RQ1 RQ2
endmodule // fmu_q15_lane

// *** design/fmu_unit.sv ***
// Fractional multiply and halfword mul-sub-accumulate execution unit.
`timescale 1ns/10ps
module fmu_unit
  import fmu_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              issue_valid,
  input  wire logic [31:0]       instr_word,
  input  wire logic [OP_W-1:0]   first_operand_reg,
  input  wire logic [OP_W-1:0]   second_operand_reg,
  input  wire logic              dsp_present,
  input  wire logic              dsp_enabled,
  output logic      [OP_W-1:0]   result_data_ff,
  output logic                   result_valid_ff,
  output logic                   acc0_touched_ff,
  output logic                   resv_instr_exc_ff,
  output logic                   dsp_disabled_exc_ff,
  output logic      [FLAG_W-1:0] ovf_flags_ff,
  output logic      [ACC_W-1:0]  acc_read_data,
  input  wire logic [1:0]        acc_read_sel
);
  ////////////////////////////////////////////////////////////////////////
  // Decode.
  wire logic        major_hit;
  wire logic        q15_hit;
  wire logic        q31_hit;
  wire logic        mulsa_hit;
  wire logic        any_hit;
  wire logic        may_exec;
  wire logic [1:0]  sum_register_select;
  fmu_op_t          op_sel;

  assign major_hit = instr_word[31:26] == MAJOR_OP;
  assign q15_hit   = major_hit && instr_word[9:0] == Q15_SUB;
  assign q31_hit   = major_hit && instr_word[9:0] == Q31_SUB;
  assign mulsa_hit = major_hit && instr_word[5:0] == MINOR_OP
                     && instr_word[13:6] == MULSA_SUB;   // RQ10
  assign sum_register_select = instr_word[15:14];         // RQ10 RQ11
  assign any_hit   = issue_valid && (q15_hit || q31_hit || mulsa_hit);
  assign may_exec  = dsp_present && dsp_enabled;          // RQ9

  // Selection chain, mul-sub first since its field overlaps.
  always_comb
  begin
    op_sel = FMU_OP_NONE;
    if (!any_hit || !may_exec)
      op_sel = FMU_OP_NONE;
    else if (mulsa_hit)
      op_sel = FMU_OP_MULSA;
    else if (q31_hit)
      op_sel = FMU_OP_Q31;
    else
      op_sel = FMU_OP_Q15;
  end

  ////////////////////////////////////////////////////////////////////////
  // Paired Q15 multiply: one lane module per halfword.
  logic [15:0] lane_res [2];
  logic [1:0]  lane_sat;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_lane
      fmu_q15_lane u_lane
      (
        .a_in     (first_operand_reg[gi*16 +: 16]),
        .b_in     (second_operand_reg[gi*16 +: 16]),
        .lane_out (lane_res[gi]),
        .lane_sat (lane_sat[gi])
      );
    end
  endgenerate
  wire logic [31:0] q15_result;
  wire logic        q15_sat;
  assign q15_result = {lane_res[1], lane_res[0]};          // RQ3
  assign q15_sat    = |lane_sat;                           // RQ1

  ////////////////////////////////////////////////////////////////////////
  // Q31 word multiply.
  wire logic signed [63:0] q31_prod;
  wire logic        [63:0] q31_shift;
  wire logic               q31_sat;
  wire logic        [31:0] q31_result;
  assign q31_prod   = $signed(first_operand_reg) * $signed(second_operand_reg);
  assign q31_shift  = {q31_prod[62:0], 1'b0};              // RQ4
  assign q31_sat    = first_operand_reg == Q31_MIN
                      && second_operand_reg == Q31_MIN;    // RQ5
  assign q31_result = q31_sat ? Q31_MAX : q31_shift[63:32]; // RQ4 RQ5

  ////////////////////////////////////////////////////////////////////////
  // Integer halfword multiply-subtract-accumulate.
  wire logic signed [31:0] prod_hi;
  wire logic signed [31:0] prod_lo;
  wire logic signed [32:0] dotp;
  wire logic        [63:0] dotp_ext;
  wire logic        [63:0] acc_sum;
  logic             [ACC_W-1:0] acc_ff [NUM_ACC];
  assign prod_hi  = $signed(first_operand_reg[31:16])
                    * $signed(second_operand_reg[31:16]);  // RQ12
  assign prod_lo  = $signed(first_operand_reg[15:0])
                    * $signed(second_operand_reg[15:0]);   // RQ12
  assign dotp     = 33'(prod_hi) - 33'(prod_lo);           // RQ12
  assign dotp_ext = {{31{dotp[32]}}, dotp};                // RQ13
  // Plain wrapping add; the integer form has no saturation.
  assign acc_sum  = acc_ff[sum_register_select] + dotp_ext; // RQ13 RQ11
  assign acc_read_data = acc_ff[acc_read_sel];

  ////////////////////////////////////////////////////////////////////////
  // Accumulators. The saturating multiplies leave every accumulator alone,
  // which is a legal choice for the base pair and required for the rest.
  generate
    for (gi = 0; gi < NUM_ACC; gi++)
    begin : g_acc
      always_ff @(posedge core_clk)
      begin
        if (rst)
          acc_ff[gi] <= '0;
        else if (op_sel == FMU_OP_MULSA && sum_register_select == 2'(gi))
          acc_ff[gi] <= acc_sum;                           // RQ13 RQ7
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Overflow flags: sticky OR only, never cleared by execution.
  wire logic [FLAG_W-1:0] set_mask;
  wire logic              sat_event;
  assign sat_event = (op_sel == FMU_OP_Q15 && q15_sat)
                     || (op_sel == FMU_OP_Q31 && q31_sat);  // RQ6 RQ14
  assign set_mask  = FLAG_W'(sat_event) << (SAT_BIT - FLAG_LSB);
  always_ff @(posedge core_clk)
  begin
    if (rst)
      ovf_flags_ff <= '0;
    else
      ovf_flags_ff <= ovf_flags_ff | set_mask;             // RQ16 RQ6
  end

  ////////////////////////////////////////////////////////////////////////
  // Result, completion and exception outputs. Exceptions come only from
  // the extension state, never from operand values.
  wire logic [31:0] nxt_result;
  assign nxt_result = (op_sel == FMU_OP_Q31) ? q31_result : q15_result;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      result_data_ff      <= '0;
      result_valid_ff     <= 1'b0;
      acc0_touched_ff     <= 1'b0;
      resv_instr_exc_ff   <= 1'b0;
      dsp_disabled_exc_ff <= 1'b0;
    end
    else
    begin
      if (op_sel == FMU_OP_Q15 || op_sel == FMU_OP_Q31)
        result_data_ff <= nxt_result;                      // RQ3 RQ4
      result_valid_ff     <= op_sel == FMU_OP_Q15 || op_sel == FMU_OP_Q31;
      acc0_touched_ff     <= op_sel == FMU_OP_MULSA
                             && sum_register_select == 2'h0;
      resv_instr_exc_ff   <= any_hit && !dsp_present;      // RQ9 RQ8
      dsp_disabled_exc_ff <= any_hit && dsp_present && !dsp_enabled; // RQ9
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks. Each implication looks one edge after the decoded operation, when the
  // registered outputs carry its effect.

  // Independent lower-lane reference, so a broken lane module shows up.
  wire logic signed [31:0] chk_lo_prod;
  wire logic               chk_lo_sat;
  wire logic               flag_bit;
  assign chk_lo_prod = $signed(first_operand_reg[15:0])
                       * $signed(second_operand_reg[15:0]);
  assign chk_lo_sat  = first_operand_reg[15:0] == Q15_MIN
                       && second_operand_reg[15:0] == Q15_MIN;
  assign flag_bit    = ovf_flags_ff[SAT_BIT-FLAG_LSB];

  // A saturating Q31 multiply returns the largest positive value.
  a_q31_sat_value: assert property ( // RQ5
    @(posedge core_clk) disable iff (rst)
    op_sel == FMU_OP_Q31 && q31_sat |=> result_data_ff == Q31_MAX)
    else $error("q31 saturation value wrong");

  // The same case leaves the overflow flag set.
  a_q31_sat_flag: assert property ( // RQ6
    @(posedge core_clk) disable iff (rst)
    op_sel == FMU_OP_Q31 && q31_sat |=> flag_bit)
    else $error("q31 saturation flag not set");

  // The lanes land in their own halves of the result.
  a_q15_pack: assert property ( // RQ3
    @(posedge core_clk) disable iff (rst)
    op_sel == FMU_OP_Q15 |=> result_data_ff == $past(q15_result))
    else $error("q15 pair packing wrong");

  // Lower lane saturation value and flag.
  a_q15_lane_sat: assert property ( // RQ1
    @(posedge core_clk) disable iff (rst)
    op_sel == FMU_OP_Q15 && chk_lo_sat
    |=> result_data_ff[15:0] == Q15_MAX && flag_bit)
    else $error("q15 lane saturation wrong");

  // Upper lane saturation value and flag.
  a_q15_hi_sat: assert property ( // RQ1
    @(posedge core_clk) disable iff (rst)
    op_sel == FMU_OP_Q15 && first_operand_reg[31:16] == Q15_MIN
    && second_operand_reg[31:16] == Q15_MIN
    |=> result_data_ff[31:16] == Q15_MAX && flag_bit)
    else $error("q15 upper lane saturation wrong");

  // An unsaturated lower lane keeps product bits 30..15.
  a_q15_trunc: assert property ( // RQ2
    @(posedge core_clk) disable iff (rst)
    op_sel == FMU_OP_Q15 && !chk_lo_sat
    |=> result_data_ff[15:0] == $past(chk_lo_prod[30:15]))
    else $error("q15 lane truncation wrong");

  // An unsaturated Q31 multiply keeps the upper shifted word.
  a_q31_trunc: assert property ( // RQ4
    @(posedge core_clk) disable iff (rst)
    op_sel == FMU_OP_Q31 && !q31_sat
    |=> result_data_ff == $past(q31_shift[63:32]))
    else $error("q31 truncation wrong");

  // No flag bit ever drops back to zero.
  a_flag_sticky: assert property ( // RQ16
    @(posedge core_clk) disable iff (rst)
    (ovf_flags_ff & $past(ovf_flags_ff)) == $past(ovf_flags_ff))
    else $error("overflow flag cleared");

  // Without a saturation event the flags do not move at all.
  a_flags_quiet: assert property ( // RQ16
    @(posedge core_clk) disable iff (rst)
    !sat_event |=> $stable(ovf_flags_ff))
    else $error("overflow flags changed without saturation");

  // Mul-sub leaves the flag field alone.
  a_mulsa_flags: assert property ( // RQ14
    @(posedge core_clk) disable iff (rst)
    op_sel == FMU_OP_MULSA |=> $stable(ovf_flags_ff))
    else $error("mul-sub touched flags");

  // The selected accumulator takes the wrapped sum.
  a_mulsa_acc: assert property ( // RQ13
    @(posedge core_clk) disable iff (rst)
    op_sel == FMU_OP_MULSA
    |=> acc_ff[$past(sum_register_select)] == $past(acc_sum))
    else $error("accumulator write wrong");

  // A non-zero select leaves the base pair alone.
  a_mulsa_sel_keep: assert property ( // RQ11
    @(posedge core_clk) disable iff (rst)
    op_sel == FMU_OP_MULSA && sum_register_select != 2'h0
    |=> $stable(acc_ff[0]))
    else $error("unselected base accumulator changed");

  // Saturating multiplies keep accumulators one to three.
  a_sat_acc_keep: assert property ( // RQ7
    @(posedge core_clk) disable iff (rst)
    op_sel == FMU_OP_Q31 || op_sel == FMU_OP_Q15
    |=> $stable(acc_ff[1]) && $stable(acc_ff[2]) && $stable(acc_ff[3]))
    else $error("accumulator changed by saturating multiply");

  // A refused instruction raises an exception and produces no result.
  a_no_exec_exc: assert property ( // RQ9
    @(posedge core_clk) disable iff (rst)
    any_hit && !may_exec |=> !result_valid_ff
    && (resv_instr_exc_ff || dsp_disabled_exc_ff))
    else $error("exception case executed");

  // The two exception kinds never stand together.
  a_exc_exclusive: assert property ( // RQ9
    @(posedge core_clk) disable iff (rst)
    !(resv_instr_exc_ff && dsp_disabled_exc_ff))
    else $error("both exception pulses raised");

  // An executed multiply never raises an exception, whatever its operands.
  a_exec_no_exc: assert property ( // RQ8
    @(posedge core_clk) disable iff (rst)
    op_sel != FMU_OP_NONE |=> !resv_instr_exc_ff && !dsp_disabled_exc_ff)
    else $error("exception raised by executed multiply");
endmodule // fmu_unit

// *** test/fmu_pipe_model.sv ***
// Issue-side model: instruction pipeline and operand read ports.
`timescale 1ns/10ps
module fmu_pipe_model
  import fmu_pkg::*;
(
  input  wire logic       core_clk,
  output logic            issue_valid,
  output logic [31:0]     instr_word,
  output logic [OP_W-1:0] first_operand_reg,
  output logic [OP_W-1:0] second_operand_reg,
  output logic            dsp_present,
  output logic            dsp_enabled
);
  typedef logic [97:0] fmu_req_t;
  fmu_req_t pend[$];
  fmu_req_t req;

  // Queue one request laid out as {word, first, second, present, enabled}.
  task automatic send(input fmu_req_t r);
    pend.push_back(r);
  endtask

  // Idle outputs at time zero; the extension starts present and enabled.
  initial
  begin
    issue_valid = 1'b0;
    instr_word = 32'h0;
    first_operand_reg = 32'h0;
    second_operand_reg = 32'h0;
    dsp_present = 1'b1;
    dsp_enabled = 1'b1;
  end

  // One request per falling edge, back to back. Idle operand lines toggle,
  // since a released read port holds no value worth trusting.
  always @(negedge core_clk)
  begin
    if (pend.size() != 0)
    begin
      req = pend.pop_front();
      {instr_word, first_operand_reg, second_operand_reg, dsp_present,
       dsp_enabled} <= req;
      issue_valid <= 1'b1;
    end
    else
    begin
      issue_valid <= 1'b0;
      first_operand_reg <= ~first_operand_reg;
      second_operand_reg <= ~second_operand_reg;
    end
  end
endmodule // fmu_pipe_model

// *** test/test_fractional_multiply_and_mulsub_unit.sv ***
// Self-checking bench for the fractional multiply and mul-sub unit.
`timescale 1ns/10ps
module test_fractional_multiply_and_mulsub_unit
  import fmu_pkg::*;
;
  typedef struct packed
  {
    logic [3:0]  kind;
    logic [31:0] data;
    logic [7:0]  flags;
  } fmu_note_t;
  logic core_clk, rst, ivld, dpres, den, rv, t0, rex, dex;
  logic [31:0] iw, opa, opb, res;
  logic [7:0]  flg;
  logic [63:0] accd;
  logic [1:0]  acc_read_sel;
  logic [63:0] exp_acc [4];
  logic [7:0]  exp_flags;
  fmu_note_t   notes[$];
  fmu_note_t   n;
  int          num_errors, samples_checked, cycles;

  fmu_pipe_model fmu_pipe_model_i (.core_clk(core_clk), .issue_valid(ivld),
    .instr_word(iw), .first_operand_reg(opa), .second_operand_reg(opb),
    .dsp_present(dpres), .dsp_enabled(den));
  fmu_unit fmu_unit_i (.core_clk(core_clk), .rst(rst), .issue_valid(ivld),
    .instr_word(iw), .first_operand_reg(opa), .second_operand_reg(opb),
    .dsp_present(dpres), .dsp_enabled(den), .result_data_ff(res),
    .result_valid_ff(rv), .acc0_touched_ff(t0), .resv_instr_exc_ff(rex),
    .dsp_disabled_exc_ff(dex), .ovf_flags_ff(flg), .acc_read_data(accd),
    .acc_read_sel(acc_read_sel));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [63:0] exp, got);
    samples_checked++;
    if (exp !== got)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask

  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Lane result with its saturation bit on top.
  function automatic logic [16:0] q15(input logic [15:0] a, b);
    logic [31:0] p;
    p = $signed(a) * $signed(b);
    if (a == Q15_MIN && b == Q15_MIN)
      return {1'b1, Q15_MAX};
    return {1'b0, p[30:15]};
  endfunction

  function automatic logic [32:0] q31(input logic [31:0] a, b);
    logic [63:0] p;
    p = $signed(a) * $signed(b);
    if (a == Q31_MIN && b == Q31_MIN)
      return {1'b1, Q31_MAX};
    return {1'b0, p[62:31]};
  endfunction

  // Issue a saturating multiply; en is {present, enabled}.
  task automatic op_q(input logic wide, input logic [31:0] a, b,
                      input logic [1:0] en);
    logic [16:0] hi, lo;
    logic [32:0] w;
    logic        s;
    hi = q15(a[31:16], b[31:16]);
    lo = q15(a[15:0], b[15:0]);
    w = q31(a, b);
    s = wide ? w[32] : (hi[16] | lo[16]);
    if (en == 2'b11)
      exp_flags[SAT_BIT-FLAG_LSB] = exp_flags[SAT_BIT-FLAG_LSB] | s;
    fmu_pipe_model_i.send({6'h00, 15'($urandom), 1'b0,
      wide ? Q31_SUB : Q15_SUB, a, b, en});
    notes.push_back('{en == 2'b11 ? 4'h8 : (en[1] ? 4'h1 : 4'h2),
      wide ? w[31:0] : {hi[15:0], lo[15:0]}, exp_flags});
  endtask

  task automatic op_ms(input logic [1:0] sel, input logic [31:0] a, b);
    logic [31:0] pb, pa;
    logic [32:0] d;
    pb = $signed(a[31:16]) * $signed(b[31:16]);
    pa = $signed(a[15:0]) * $signed(b[15:0]);
    d = {pb[31], pb} - {pa[31], pa};
    exp_acc[sel] = exp_acc[sel] + {{31{d[32]}}, d};
    fmu_pipe_model_i.send({6'h00, 10'($urandom), sel, MULSA_SUB, MINOR_OP,
      a, b, 2'b11});
    if (sel == 2'd0)
      notes.push_back('{4'h4, 32'h0, exp_flags});
  endtask

  task automatic drain;
    while (fmu_pipe_model_i.pend.size() != 0 || notes.size() != 0)
      @(negedge core_clk);
    repeat (3) @(negedge core_clk);
  endtask

  task automatic acc_check(input int first);
    for (int s = first; s < 4; s++)
    begin
      acc_read_sel = s[1:0];
      #1;
      check("accumulator", exp_acc[s], accd);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Each pulse retires the oldest note; a pulse with no note is a mismatch.
  always @(negedge core_clk)
  begin
    if (!rst && {rv, t0, rex, dex} !== 4'h0)
    begin
      n = (notes.size() != 0) ? notes.pop_front() : '0;
      check("pulse kind", n.kind, {rv, t0, rex, dex});
      if (n.kind[3])
        check("result", n.data, res);
      check("flags", n.flags, flg);
    end
  end

  // Clock, and a cycle ceiling well above the expected run length.
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      num_errors++;
      $display("[ERR] cycle limit expected 4000 seen %0d", cycles);
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    acc_read_sel = 2'd0;
    exp_flags = 8'h00;
    exp_acc = '{default: 64'h0};
    num_errors = 0;
    samples_checked = 0;
    cycles = 0;
    void'($urandom(32'h201d608b));
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    // Refused and unknown words, all but the last with saturating operands, change nothing.
    op_q(1'b1, Q31_MIN, Q31_MIN, 2'b01);
    op_q(1'b0, 32'h80008000, 32'h80008000, 2'b10);
    fmu_pipe_model_i.send({6'h01, 16'h0, Q31_SUB, Q31_MIN, Q31_MIN, 2'b11});
    fmu_pipe_model_i.send({16'h0, 2'd1, 8'hB3, MINOR_OP, 64'h0, 2'b11});
    // Mul-sub into every accumulator, extreme products first.
    for (int i = 0; i < 12; i++)
      op_ms(i[1:0], i < 4 ? (i[0] ? 32'h7FFF8000 : 32'h80007FFF) : $urandom,
        i < 4 ? 32'h80008000 : $urandom);
    drain();
    acc_check(0);
    // Saturation corners, then random traffic, all back to back.
    op_q(1'b0, 32'h7FFF8000, 32'h80007FFF, 2'b11);
    op_q(1'b1, Q31_MIN, Q31_MAX, 2'b11);
    op_q(1'b0, 32'h80001234, 32'h8000FFFF, 2'b11);
    op_q(1'b0, 32'h12348000, 32'hFFFF8000, 2'b11);
    op_q(1'b1, Q31_MIN, Q31_MIN, 2'b11);
    op_ms(2'd2, $urandom, $urandom);
    for (int i = 0; i < 30; i++)
      op_q(1'($urandom), $urandom, $urandom, 2'b11);
    drain();
    // Accumulator zero is the caller's to save, so only one to three count.
    acc_check(1);
    test_done();
  end
endmodule // test_fractional_multiply_and_mulsub_unit
